/* pkg/seip_mem_if.sv */
// Purpose: link between instruction decoder and array/programming engine
// Assumes: one clock domain
// Notes:   read path is combinational from rd_addr
interface seip_mem_if;
    import seip_pkg::*;
    logic                  req;
    seip_prog_op_t         op;
    logic [AW-1:0]         addr;
    logic [DW-1:0]         data;
    logic                  wide;
    logic                  busy;
    logic [AW-1:0]         rd_addr;
    logic [DW-1:0]         rd_word;

    modport ctrl (output req, op, addr, data, wide, rd_addr, input busy, rd_word);
    modport array (input req, op, addr, data, wide, rd_addr, output busy, rd_word);
endinterface

/* pkg/seip_pkg.sv */
// Purpose: shared constants and types of the serial eeprom instruction port
// Assumes: 4 kbit density variant, 20 MHz system clock
// Notes:   program time is a nominal figure, shortened by the top parameter
package seip_pkg;
    // ==========================================================
    // opcodes and extended selectors
    localparam logic [1:0] OPC_EXT    = 2'h0;
    localparam logic [1:0] OPC_WRITE  = 2'h1;
    localparam logic [1:0] OPC_READ   = 2'h2;
    localparam logic [1:0] OPC_ERASE  = 2'h3;
    localparam logic [1:0] EXT_LOCK   = 2'h0;
    localparam logic [1:0] EXT_FILL   = 2'h1;
    localparam logic [1:0] EXT_CLEAR  = 2'h2;
    localparam logic [1:0] EXT_UNLOCK = 2'h3;

    // ==========================================================
    // field widths and array size
    localparam int AW            = 9;
    localparam int DW            = 16;
    localparam int ADDR_BITS_X8  = 9;
    localparam int ADDR_BITS_X16 = 8;
    localparam int DATA_BITS_X8  = 8;
    localparam int DATA_BITS_X16 = 16;
    localparam int ARRAY_BYTES   = 512;
    localparam int TMR_W         = 24;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS   = 50;
    localparam int STATUS_WAIT_NS  = 200;
    localparam int STATUS_WAIT_CYC = (STATUS_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_TIME_NS    = 5000000;
    localparam int PROG_CYC        = PROG_TIME_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {PG_NONE, PG_WRITE, PG_FILL, PG_ERASE, PG_CLEAR} seip_prog_op_t;
endpackage

/* rtl/seip_array.sv */
// Purpose: storage array and self-timed programming engine
// Assumes: requests only arrive while idle
// Notes:   array has no reset, contents survive a reset like a real cell
module seip_array #(
    parameter int unsigned PROG_CYCLES = seip_pkg::PROG_CYC
) (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic ce,
    seip_mem_if.array mem
);
    import seip_pkg::*;
    typedef enum logic [1:0] {P_IDLE, P_APPLY, P_WAIT} seip_pg_state_t;

    logic [7:0]     mem_q [ARRAY_BYTES];
    seip_pg_state_t st_q, st_d;
    seip_prog_op_t  op_q, op_d;
    logic [DW-1:0]  data_q, data_d;
    logic           wide_q, wide_d;
    logic [AW-1:0]  cur_q, cur_d;
    logic [AW-1:0]  last_q, last_d;
    logic [TMR_W-1:0] tmr_q, tmr_d;
    logic           we;
    logic [7:0]     wdata;
    logic           single;

    // ==========================================================
    // sequencer: bytes are laid down first, then the cell time runs
    always_comb begin
        st_d   = st_q;
        op_d   = op_q;
        data_d = data_q;
        wide_d = wide_q;
        cur_d  = cur_q;
        last_d = last_q;
        tmr_d  = tmr_q;
        we     = 1'b0;
        wdata  = ERASED_BYTE;
        single = (mem.op == PG_WRITE) || (mem.op == PG_ERASE);
        case (st_q)
            P_IDLE: if (mem.req) begin
                op_d   = mem.op;
                data_d = mem.data;
                wide_d = mem.wide;
                if (single) begin
                    cur_d  = mem.wide ? {mem.addr[7:0], 1'b0} : mem.addr;
                    last_d = mem.wide ? {mem.addr[7:0], 1'b1} : mem.addr;
                end else begin
                    cur_d  = '0;
                    last_d = AW'(ARRAY_BYTES - 1);
                end
                st_d = P_APPLY;
            end
            P_APPLY: begin
                we = 1'b1;
                // a write simply overwrites: erase-before-write gives the same cell value
                if (op_q == PG_WRITE || op_q == PG_FILL) begin
                    wdata = (wide_q && cur_q[0]) ? data_q[15:8] : data_q[7:0];
                end
                if (cur_q == last_q) begin
                    st_d  = P_WAIT;
                    tmr_d = TMR_W'(PROG_CYCLES - 1);
                end else begin
                    cur_d = cur_q + 9'h001;
                end
            end
            P_WAIT: begin
                if (tmr_q == '0) begin
                    st_d = P_IDLE;
                end else begin
                    tmr_d = tmr_q - 24'h000001;
                end
            end
            default: st_d = P_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_q   <= P_IDLE;
            op_q   <= PG_NONE;
            data_q <= '0;
            wide_q <= 1'b0;
            cur_q  <= '0;
            last_q <= '0;
            tmr_q  <= '0;
        end else if (ce) begin
            st_q   <= st_d;
            op_q   <= op_d;
            data_q <= data_d;
            wide_q <= wide_d;
            cur_q  <= cur_d;
            last_q <= last_d;
            tmr_q  <= tmr_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (ce && we) begin
            mem_q[cur_q] <= wdata;
        end
    end

    assign mem.busy    = (st_q != P_IDLE);
    assign mem.rd_word = mem.wide ? {mem_q[{mem.rd_addr[7:0], 1'b1}],
                                     mem_q[{mem.rd_addr[7:0], 1'b0}]}
                                  : {8'h00, mem_q[mem.rd_addr]};
endmodule

/* rtl/seip_edge.sv */
// Purpose: rise and fall detection of a synchronous pin input
// Assumes: input already synchronous to clk_sys
// Notes:   frozen with ce so an edge is never lost while frozen
module seip_edge (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic ce,
    input  wire logic sig,
    output logic      rise,
    output logic      fall
);
    logic prev_q;
    logic prev_d;

    always_comb begin
        prev_d = sig;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            prev_q <= 1'b0;
        end else if (ce) begin
            prev_q <= prev_d;
        end
    end

    assign rise = sig & ~prev_q;
    assign fall = ~sig & prev_q;
endmodule

/* rtl/seip_port.sv */
// Purpose: serial instruction port of a small serial eeprom
// Assumes: cs, serial_clock, din and org synchronous to clk_sys
// Notes:   serial_clock is sampled, so it must stay well below clk_sys / 2
//
// Notes on behaviour
// - din is sampled on each serial_clock rise while cs is high.
// - instruction is start bit one, 2-bit opcode, address, then data.
// - state holds indefinitely while serial_clock stands still.
// - cs low enters standby, but only after programming finishes.
// - read and the busy/ready status drive dout; addressed word loads into the output shifter.
// - read sends one dummy zero bit before the 8 or 16 data bits.
// - dout changes on serial_clock rises while read data shifts out.
// - read continues at the next address, wrapping, until cs falls.
// - powers up write-disabled; programming instructions ignored until enabled.
// - write enable stays set until write disable or power loss.
// - with write enable set, cs fall after a write starts programming.
// - cs raised during programming shows dout low while busy, high when ready.
// - no status if cs rises after programming; din-high clock rise clears it.
// - fill_all programs every location, status reported like a write.
// - program_lock clears write enable, blocking all programming.
// - cs fall after erase starts it; cs high shows busy then ready.
// - org high selects 16-bit words, org low selects bytes.
// - array is 512 bytes or 256 words.
// - wrong bit count rejects programming, still accepts read and enable/lock.
// - clear_all sets every bit of the array to one, self-timed.
module seip_port #(
    parameter int unsigned PROG_CYCLES = seip_pkg::PROG_CYC
) (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic ce,
    input  wire logic cs,
    input  wire logic serial_clock,
    input  wire logic din,
    input  wire logic org,
    output logic      dout,
    output logic      dout_oe,
    output logic      standby
);
    import seip_pkg::*;
    typedef enum logic [2:0] {S_IDLE, S_OPC, S_ADDR, S_DATA, S_READ, S_WAIT} seip_state_t;

    seip_state_t   state_q, state_d;
    seip_prog_op_t pend_q, pend_d;
    logic [4:0]    cnt_q, cnt_d;
    logic [1:0]    opc_q, opc_d;
    logic [AW-1:0] addr_q, addr_d;
    logic [DW-1:0] data_q, data_d;
    logic [DW-1:0] sh_q, sh_d;
    logic          wen_q, wen_d;
    logic          status_q, status_d;
    logic          extra_q, extra_d;
    logic          req_q, req_d;
    logic          dout_q, dout_d;
    logic          oe_q, oe_d;
    logic          stby_q, stby_d;
    logic          sk_rise;
    logic          cs_rise;
    logic          cs_fall;
    logic          busy_any;
    logic [AW-1:0] a_next;
    logic [AW-1:0] addr_inc;
    logic [1:0]    ext_sel;
    logic [4:0]    addr_len;
    logic [4:0]    data_len;
    logic [DW-1:0] rd_al;

    seip_mem_if mif ();

    // ==========================================================
    // pin edges and array
    seip_edge u_sk_edge (
        .clk_sys (clk_sys),
        .reset   (reset),
        .ce      (ce),
        .sig     (serial_clock),
        .rise    (sk_rise),
        .fall    ()
    );

    seip_edge u_cs_edge (
        .clk_sys (clk_sys),
        .reset   (reset),
        .ce      (ce),
        .sig     (cs),
        .rise    (cs_rise),
        .fall    (cs_fall)
    );

    seip_array #(.PROG_CYCLES(PROG_CYCLES)) u_array (
        .clk_sys (clk_sys),
        .reset   (reset),
        .ce      (ce),
        .mem     (mif.array)
    );

    // ==========================================================
    // address arithmetic and organisation
    always_comb begin
        a_next   = {addr_q[AW-2:0], din};
        ext_sel  = org ? a_next[7:6] : a_next[8:7];
        addr_inc = org ? {1'b0, addr_q[7:0] + 8'h01} : addr_q + 9'h001;
        addr_len = org ? 5'(ADDR_BITS_X16) : 5'(ADDR_BITS_X8);
        data_len = org ? 5'(DATA_BITS_X16) : 5'(DATA_BITS_X8);
        rd_al    = org ? mif.rd_word : {mif.rd_word[7:0], 8'h00};
    end

    assign busy_any    = mif.busy | req_q;
    assign mif.req     = req_q;
    assign mif.op      = pend_q;
    assign mif.addr    = addr_q;
    assign mif.data    = data_q;
    assign mif.wide    = org;
    assign mif.rd_addr = (state_q == S_ADDR) ? a_next : addr_inc;

    // ==========================================================
    // instruction sequencer
    always_comb begin
        state_d  = state_q;
        pend_d   = pend_q;
        cnt_d    = cnt_q;
        opc_d    = opc_q;
        addr_d   = addr_q;
        data_d   = data_q;
        sh_d     = sh_q;
        wen_d    = wen_q;
        status_d = status_q;
        extra_d  = extra_q;
        req_d    = 1'b0;
        dout_d   = dout_q;
        if (cs_fall) begin
            // short or long instructions never reach a clean S_WAIT
            if (state_q == S_WAIT && pend_q != PG_NONE && !extra_q
                && wen_q && !busy_any) begin
                req_d    = 1'b1;
                status_d = 1'b1;
            end
            state_d = S_IDLE;
            extra_d = 1'b0;
            if (!(state_q == S_WAIT && pend_q != PG_NONE)) begin
                pend_d = PG_NONE;
            end
        end else if (cs_rise) begin
            if (!busy_any) begin
                status_d = 1'b0;
            end
        end else if (cs && sk_rise) begin
            case (state_q)
                S_IDLE: if (din) begin
                    status_d = 1'b0;
                    // a start bit is ignored, not queued, while a cycle is running
                    if (!busy_any) begin
                        state_d = S_OPC;
                        cnt_d   = '0;
                        pend_d  = PG_NONE;
                    end
                end
                S_OPC: begin
                    opc_d = {opc_q[0], din};
                    if (cnt_q == 5'h01) begin
                        state_d = S_ADDR;
                        cnt_d   = '0;
                    end else begin
                        cnt_d = cnt_q + 5'h01;
                    end
                end
                S_ADDR: begin
                    addr_d = a_next;
                    if (cnt_q == addr_len - 5'h01) begin
                        cnt_d = '0;
                        case (opc_q)
                            OPC_READ: begin
                                state_d = S_READ;
                                sh_d    = rd_al;
                                dout_d  = 1'b0;
                                cnt_d   = data_len;
                            end
                            OPC_WRITE: state_d = S_DATA;
                            OPC_ERASE: begin
                                state_d = S_WAIT;
                                pend_d  = PG_ERASE;
                            end
                            default: begin
                                state_d = S_WAIT;
                                if (ext_sel == EXT_LOCK) begin
                                    wen_d = 1'b0;
                                end else if (ext_sel == EXT_UNLOCK) begin
                                    wen_d = 1'b1;
                                end else if (ext_sel == EXT_FILL) begin
                                    state_d = S_DATA;
                                end else begin
                                    pend_d = PG_CLEAR;
                                end
                            end
                        endcase
                    end else begin
                        cnt_d = cnt_q + 5'h01;
                    end
                end
                S_DATA: begin
                    data_d = {data_q[DW-2:0], din};
                    if (cnt_q == data_len - 5'h01) begin
                        state_d = S_WAIT;
                        pend_d  = (opc_q == OPC_WRITE) ? PG_WRITE : PG_FILL;
                    end else begin
                        cnt_d = cnt_q + 5'h01;
                    end
                end
                S_READ: begin
                    dout_d = sh_q[DW-1];
                    if (cnt_q == 5'h01) begin
                        sh_d   = rd_al;
                        addr_d = addr_inc;
                        cnt_d  = data_len;
                    end else begin
                        sh_d  = {sh_q[DW-2:0], 1'b0};
                        cnt_d = cnt_q - 5'h01;
                    end
                end
                S_WAIT: extra_d = 1'b1;
                default: state_d = S_IDLE;
            endcase
        end
        oe_d = cs && !cs_fall && ((state_d == S_READ) || status_d);
        if (oe_d && state_d != S_READ) begin
            dout_d = !busy_any;
        end else if (!oe_d) begin
            dout_d = 1'b0;
        end
        // a start issued at this very cs fall is not busy yet, keep standby off
        stby_d = !cs && !busy_any && !req_d;
    end

    // ==========================================================
    // state registers, frozen with ce
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q  <= S_IDLE;
            pend_q   <= PG_NONE;
            cnt_q    <= '0;
            opc_q    <= '0;
            addr_q   <= '0;
            data_q   <= '0;
            sh_q     <= '0;
            wen_q    <= 1'b0;
            status_q <= 1'b0;
            extra_q  <= 1'b0;
            req_q    <= 1'b0;
            dout_q   <= 1'b0;
            oe_q     <= 1'b0;
            stby_q   <= 1'b0;
        end else if (ce) begin
            state_q  <= state_d;
            pend_q   <= pend_d;
            cnt_q    <= cnt_d;
            opc_q    <= opc_d;
            addr_q   <= addr_d;
            data_q   <= data_d;
            sh_q     <= sh_d;
            wen_q    <= wen_d;
            status_q <= status_d;
            extra_q  <= extra_d;
            req_q    <= req_d;
            dout_q   <= dout_d;
            oe_q     <= oe_d;
            stby_q   <= stby_d;
        end
    end

    assign dout    = dout_q;
    assign dout_oe = oe_q;
    assign standby = stby_q;

    // ==========================================================
    // checks
    lock_at_reset_a: assert property (@(posedge clk_sys) disable iff (reset)
        $past(reset) |-> !wen_q) else $error("write enable set after reset");

    start_needs_wen_a: assert property (@(posedge clk_sys) disable iff (reset)
        req_q |-> $past(wen_q) && $past(cs_fall) && $past(ce))
        else $error("program start without enable or cs fall");

    reject_extra_a: assert property (@(posedge clk_sys) disable iff (reset)
        req_q |-> !$past(extra_q)) else $error("program start after extra bits");

    lock_clears_a: assert property (@(posedge clk_sys) disable iff (reset)
        (ce && cs && !cs_fall && !cs_rise && sk_rise && state_q == S_ADDR && opc_q == OPC_EXT
         && cnt_q == addr_len - 5'h01 && ext_sel == EXT_LOCK) |=> !wen_q)
        else $error("lock did not clear write enable");

    dummy_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(state_q == S_READ) |-> oe_q && !dout_q) else $error("no dummy zero");

    read_edge_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state_q == S_READ && $past(state_q == S_READ) && $changed(dout_q))
        |-> $past(sk_rise)) else $error("read data moved without clock rise");

    drive_only_cs_a: assert property (@(posedge clk_sys) disable iff (reset)
        oe_q |-> $past(cs)) else $error("dout driven with cs low");

    status_level_a: assert property (@(posedge clk_sys) disable iff (reset)
        (oe_q && $past(ce) && $past(status_d) && $past(state_d) != S_READ)
        |-> dout_q == !$past(busy_any)) else $error("wrong ready busy level");

    standby_busy_a: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(standby) |-> $past(!cs) && $past(!busy_any) && !busy_any)
        else $error("standby while busy");

    freeze_ce_a: assert property (@(posedge clk_sys) disable iff (reset)
        $past(!ce) |-> $stable(state_q) && $stable(dout_q) && $stable(wen_q))
        else $error("state moved while frozen");
endmodule

/* verification/seip_host.sv */
// Purpose: host model driving the serial instruction port
// Assumes: serial_clock high half lasts two clk_sys cycles, low half three
// Notes:   serial_clock stands low between frames
module seip_host (
    input  wire logic clk_sys,
    input  wire logic dout,
    input  wire logic dout_oe,
    output logic      cs,
    output logic      serial_clock,
    output logic      din
);
    timeunit 1ns;
    timeprecision 100ps;
    logic so;
    logic pin;
    // a released pin reads inverted, so a sample taken while undriven shows up
    assign pin = dout_oe ? dout : ~dout;
    initial begin
        cs = 1'b0;
        serial_clock = 1'b0;
        din = 1'b0;
    end
    // ======================================================
    // bit, frame and status tasks
    task automatic shift(input logic b);
        @(posedge clk_sys) #1;
        din = b;
        serial_clock = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 serial_clock = 1'b0;
        so = pin;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    task automatic send(input logic [31:0] v, input int n);
        if (!cs) begin
            @(posedge clk_sys) #1 cs = 1'b1;
        end
        for (int i = n - 1; i >= 0; i--) shift(v[i]);
    endtask
    // cs drops before any further rise; wait covers the status delay
    task automatic drop();
        @(posedge clk_sys) #1 cs = 1'b0;
        din = ~din;
        repeat (6) @(posedge clk_sys);
        #1;
    endtask
    task automatic status(output logic oe, output logic b0, output logic rdy);
        @(posedge clk_sys) #1 cs = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 oe = dout_oe;
        b0 = pin;
        rdy = pin;
        for (int i = 0; i < 2000 && !rdy && oe; i++) begin
            @(posedge clk_sys) #1 rdy = pin;
        end
    endtask
endmodule

/* verification/seip_port_tb.sv */
// Purpose: self-checking bench of the serial instruction port
// Assumes: short program time, array cleared before any read
// Notes:   byte model in integers, x16 word a is bytes 2a and 2a+1
module seip_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import seip_pkg::*;
    logic        clk_sys = 1'b0;
    logic        reset;
    logic        ce;
    logic        org;
    logic        cs;
    logic        serial_clock;
    logic        din;
    logic        dout;
    logic        dout_oe;
    logic        standby;
    logic [31:0] seed = 32'h3c;
    logic [15:0] p;
    int          mem [512];
    int          bad_count = 0;
    int          n_checks = 0;
    int          a;
    logic        s_oe;
    logic        s_b0;
    logic        s_rdy;
    always #25 clk_sys = ~clk_sys;
    seip_port #(.PROG_CYCLES(20)) i_dut (.clk_sys(clk_sys), .reset(reset), .ce(ce), .cs(cs),
        .serial_clock(serial_clock), .din(din), .org(org), .dout(dout), .dout_oe(dout_oe),
        .standby(standby));
    seip_host host (.clk_sys(clk_sys), .dout(dout), .dout_oe(dout_oe), .cs(cs),
        .serial_clock(serial_clock), .din(din));
    // ======================================================
    // helpers
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int ext(input logic [1:0] s);
        return org ? int'(s) << 6 : int'(s) << 7;
    endfunction
    task automatic summarize();
        if (bad_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: data %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    // go: a programming cycle must start and report busy then ready
    task automatic prog(input logic [1:0] opc, input int ad, input logic [31:0] d,
                        input int nd, input bit go);
        logic oe, b0, rdy;
        host.send({1'b1, opc}, 3);
        host.send(ad, org ? 8 : 9);
        if (nd > 0) host.send(d, nd);
        host.drop();
        chk_bit(standby, !go);
        // freeze mid-cycle: the programming timer must resume, not restart
        if (go) begin
            ce = 1'b0;
            repeat (4) @(posedge clk_sys);
            #1 ce = 1'b1;
        end
        host.status(oe, b0, rdy);
        chk_bit(oe, go);
        if (go) begin
            chk_bit(b0, 1'b0);
            if (!rdy) begin
                bad_count++;
                $display("Error %0t: ready never seen", $time);
                summarize();
            end
            host.shift(1'b1);
            chk_bit(dout_oe, 1'b0);
        end
        host.drop();
        chk_bit(standby, 1'b1);
    endtask
    task automatic rd(input int ad, input int cnt);
        logic [15:0] got;
        int x;
        host.send(3'b110, 3);
        host.send(ad, org ? 8 : 9);
        chk_bit(dout_oe, 1'b1);
        chk_bit(host.so, 1'b0);
        for (int k = 0; k < cnt; k++) begin
            got = '0;
            for (int j = 0; j < (org ? 16 : 8); j++) begin
                host.shift(1'b0);
                got = {got[14:0], host.so};
            end
            x = org ? (ad + k) % 256 : (ad + k) % 512;
            chk_val(got, org ? 16'(mem[2*x+1] * 256 + mem[2*x]) : 16'(mem[x]));
        end
        host.drop();
        chk_bit(dout_oe, 1'b0);
    endtask
    // ======================================================
    // main sequence
    initial begin
        reset = 1'b1;
        ce = 1'b1;
        org = 1'b0;
        repeat (8) @(posedge clk_sys);
        #1 reset = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 chk_bit(standby, 1'b1);
        prog(OPC_EXT, ext(EXT_CLEAR), 0, 0, 0);
        prog(OPC_EXT, ext(EXT_UNLOCK), 0, 0, 0);
        prog(OPC_EXT, ext(EXT_CLEAR), 0, 0, 1);
        foreach (mem[i]) mem[i] = 255;
        for (int k = 0; k < 6; k++) begin
            a = (k == 0) ? 511 : (k == 1) ? 0 : int'(xs() & 511);
            p = 16'(xs() & 255);
            prog(OPC_WRITE, a, p, 8, 1);
            mem[a] = p;
        end
        // late cs rise after the erase is done: no status shown
        host.send(3'b111, 3);
        host.send(511, 9);
        host.drop();
        mem[511] = 255;
        repeat (40) @(posedge clk_sys);
        host.status(s_oe, s_b0, s_rdy);
        chk_bit(s_oe, 1'b0);
        host.drop();
        rd(509, 5);
        org = 1'b1;
        rd(254, 3);
        prog(OPC_ERASE, 255, 0, 0, 1);
        mem[510] = 255;
        mem[511] = 255;
        p = 16'(xs());
        prog(OPC_WRITE, 3, p, 16, 1);
        mem[6] = p[7:0];
        mem[7] = p[15:8];
        prog(OPC_WRITE, 3, 16'(xs()), 15, 0);
        prog(OPC_WRITE, 3, xs(), 17, 0);
        rd(254, 6);
        prog(OPC_EXT, ext(EXT_LOCK), 0, 0, 0);
        prog(OPC_WRITE, 3, 16'(xs()), 16, 0);
        prog(OPC_EXT, ext(EXT_FILL), 16'(xs()), 16, 0);
        rd(3, 1);
        prog(OPC_EXT, ext(EXT_UNLOCK), 0, 0, 0);
        p = 16'(xs());
        prog(OPC_EXT, ext(EXT_FILL), p, 16, 1);
        for (int i = 0; i < 256; i++) begin
            mem[2*i] = p[7:0];
            mem[2*i+1] = p[15:8];
        end
        rd(100, 2);
        org = 1'b0;
        rd(511, 2);
        // reset while write enabled must leave the port write-disabled
        prog(OPC_EXT, ext(EXT_UNLOCK), 0, 0, 0);
        reset = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 reset = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 prog(OPC_WRITE, 5, 16'(xs() & 255), 8, 0);
        rd(5, 1);
        prog(OPC_EXT, ext(EXT_LOCK), 0, 0, 0);
        summarize();
    end
endmodule
